// >>> hw/flash_seq_top.sv
// How it works
// - Bytes past the page end wrap to the first byte of the same page.
// - Over 256 data bytes: only the last 256 are programmed, same page.
// - Under 256 bytes: only received bytes are written, rest of page untouched.
// - Program runs only if select rises right after a whole data byte.
// - Select rise after a valid program starts the timed load cycle.
// - Busy flag is 1 during any timed cycle and 0 once it ends and all page writes have drained.
// - Write latch flag clears before each timed cycle completes.
// - Program to a guarded page is rejected, memory unchanged.
// - Four-lane program 32h is accepted only when quad lanes are allowed.
// - Four-lane program behaves like single-lane program in every other way.
// - Any address inside a sector or block selects that whole region.
// - Erase runs only if select rises right after the last address byte.
// - Valid sector erase starts the timed small clear cycle.
// - Erase of a guarded region does not execute.
// - Valid block erase of either size starts the timed large clear cycle.
`timescale 1ns/1ps
module flash_seq_top
  import flash_seq_pkg::*;
#(
  parameter int LOAD_CYCLE_CNT  = LOAD_CYCLES,
  parameter int SMALL_CLEAR_CNT = SMALL_CYCLES,
  parameter int LARGE_CLEAR_CNT = LARGE_CYCLES
)(
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  input  wire link_pins_s  link_i,
  input  wire logic        quad_lane_allow_i,
  input  wire logic [4:0]  region_guard_bits_i,
  output mem_write_s       mem_wr_o,
  output logic             mem_wr_valid_o,
  input  wire logic        mem_wr_ready_i,
  output clear_req_s       clear_o,
  output logic             clear_valid_o,
  output logic             busy_status_flag_o,
  output logic             write_latch_flag_o
);

  // Guard decode: protected span is a prefix or suffix of the array
  function automatic logic guarded(input logic [ADDR_W-1:0] a, input logic [4:0] g);
    int   span_log;
    logic hit;
    span_log = (g[GUARD_FINE] ? GUARD_FINE_LOG : GUARD_WIDE_LOG)
               + int'(g[GUARD_CNT_W-1:0]) - 1;
    hit = (g[GUARD_CNT_W-1:0] != '0);
    for (int i = 0; i < ADDR_W; i++)
      if (i >= span_log && a[i] != !g[GUARD_BOTTOM])
        hit = 1'b0;
    return hit;
  endfunction

  // Pin synchronisers; the link clock is sampled, not used as a clock
  link_pins_s sync1_reg, sync2_reg, prev_reg;

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync1_reg <= LINK_IDLE;
      sync2_reg <= LINK_IDLE;
      prev_reg  <= LINK_IDLE;
    end
    else if (ce_i)
    begin
      sync1_reg <= link_i;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  logic sclk_rise, cs_rise, cs_fall;
  assign sclk_rise = sync2_reg.sclk && !prev_reg.sclk && !sync2_reg.cs_n;
  assign cs_rise   = sync2_reg.cs_n && !prev_reg.cs_n;
  assign cs_fall   = !sync2_reg.cs_n && prev_reg.cs_n;

  // Command parser state
  phase_e            phase_reg, phase_next;
  logic [7:0]        op_reg, op_next;
  logic [7:0]        shift_reg, shift_next;
  logic [3:0]        bits_reg, bits_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [1:0]        acnt_reg, acnt_next;
  logic [PAGE_W-1:0] col_reg, col_next;
  logic              seen_reg, seen_next;
  logic              quad_reg, quad_next;
  logic              buf_we, vld_clr;

  // Timed cycle state
  logic               busy_reg, busy_next;
  logic               wlatch_reg, wlatch_next;
  logic [TIMER_W-1:0] timer_reg, timer_next;
  logic               walk_reg, walk_next;
  logic [PAGE_W-1:0]  widx_reg, widx_next;
  logic [ROW_W-1:0]   row_reg, row_next;
  clear_req_s         clear_reg, clear_next;
  logic               cvalid_reg, cvalid_next;

  // Page buffer and per-byte valid marks
  logic [7:0]            pbuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pvld_reg;

  logic [3:0]        step;
  logic [3:0]        bits_sum;
  logic [7:0]        shifted;
  logic              is_prog, is_clear, prog_go, clear_go, unlock_go, start;
  logic              prot;
  logic [ADDR_W-1:0] rmask;
  clear_size_e       csize;
  logic              push_valid, push_ready;

  assign step     = (quad_reg && phase_reg != PH_OPCODE) ? QUAD_STEP : SINGLE_STEP;
  assign shifted  = (step == QUAD_STEP) ? {shift_reg[3:0], sync2_reg.lanes}
                                        : {shift_reg[6:0], sync2_reg.lanes[0]};
  assign bits_sum = bits_reg + step;

  always_comb
  begin
    phase_next = phase_reg;
    op_next    = op_reg;
    shift_next = shift_reg;
    bits_next  = bits_reg;
    addr_next  = addr_reg;
    acnt_next  = acnt_reg;
    col_next   = col_reg;
    seen_next  = seen_reg;
    quad_next  = quad_reg;
    buf_we     = 1'b0;
    vld_clr    = 1'b0;
    if (cs_fall)
    begin
      phase_next = PH_OPCODE;
      bits_next  = '0;
      acnt_next  = '0;
      seen_next  = 1'b0;
      quad_next  = 1'b0;
      vld_clr    = !busy_reg;
    end
    else if (cs_rise)
      phase_next = PH_IDLE;
    else if (sclk_rise && phase_reg != PH_IDLE)
    begin
      shift_next = shifted;
      bits_next  = bits_sum;
      if (bits_sum == BITS_PER_BYTE)
      begin
        bits_next = '0;
        case (phase_reg)
          PH_OPCODE:
          begin
            op_next    = shifted;
            quad_next  = (shifted == WIDE_BYTE_LOAD_OP);
            phase_next = PH_ADDR;
          end
          PH_ADDR:
          begin
            addr_next = {addr_reg[ADDR_W-9:0], shifted};
            acnt_next = acnt_reg + 2'h1;
            if (acnt_reg == ADDR_BYTES_M1)
            begin
              phase_next = PH_DATA;
              col_next   = shifted;
            end
          end
          PH_DATA:
          begin
            buf_we    = !busy_reg;
            col_next  = col_reg + 8'h01;
            seen_next = 1'b1;
          end
          default: phase_next = PH_IDLE;
        endcase
      end
    end
  end

  // Command qualification at the select rise
  always_comb
  begin
    is_prog  = (op_reg == BYTE_LOAD_OP) || (op_reg == WIDE_BYTE_LOAD_OP);
    is_clear = (op_reg == SMALL_REGION_CLEAR_OP) || (op_reg == LARGE_REGION_CLEAR_OP_32K)
               || (op_reg == LARGE_REGION_CLEAR_OP_64K);
    case (op_reg)
      SMALL_REGION_CLEAR_OP:     csize = CLR_SECTOR;
      LARGE_REGION_CLEAR_OP_32K: csize = CLR_BLOCK32;
      default:                   csize = CLR_BLOCK64;
    endcase
    if (is_prog)
      rmask = PAGE_MASK;
    else if (csize == CLR_SECTOR)
      rmask = SECTOR_MASK;
    else if (csize == CLR_BLOCK32)
      rmask = BLOCK32_MASK;
    else
      rmask = BLOCK64_MASK;
    prot = guarded(addr_reg & ~rmask, region_guard_bits_i)
           || guarded(addr_reg | rmask, region_guard_bits_i);
    prog_go = cs_rise && is_prog && phase_reg == PH_DATA && bits_reg == '0 && seen_reg
              && !busy_reg && wlatch_reg && !prot
              && (!quad_reg || quad_lane_allow_i);
    clear_go = cs_rise && is_clear && phase_reg == PH_DATA && bits_reg == '0 && !seen_reg
               && !busy_reg && wlatch_reg && !prot;
    unlock_go = cs_rise && op_reg == WRITE_UNLOCK_OP && phase_reg == PH_ADDR
                && acnt_reg == '0 && bits_reg == '0 && !busy_reg;
    start = prog_go || clear_go;
  end

  assign push_valid = walk_reg && pvld_reg[widx_reg];

  always_comb
  begin
    busy_next   = busy_reg;
    wlatch_next = wlatch_reg;
    timer_next  = timer_reg;
    walk_next   = walk_reg;
    widx_next   = widx_reg;
    row_next    = row_reg;
    clear_next  = clear_reg;
    cvalid_next = 1'b0;
    if (unlock_go)
      wlatch_next = 1'b1;
    if (start)
    begin
      busy_next   = 1'b1;
      wlatch_next = 1'b0;
      walk_next   = prog_go;
      widx_next   = '0;
      row_next    = addr_reg[ADDR_W-1:PAGE_W];
      if (prog_go)
        timer_next = TIMER_W'(LOAD_CYCLE_CNT - 1);
      else if (csize == CLR_SECTOR)
        timer_next = TIMER_W'(SMALL_CLEAR_CNT - 1);
      else
        timer_next = TIMER_W'(LARGE_CLEAR_CNT - 1);
      cvalid_next = clear_go;
      clear_next  = '{base: addr_reg & ~rmask, size: csize};
    end
    else if (busy_reg)
    begin
      // Busy lasts for the timed cycle or until the page is drained, whichever is later
      if (timer_reg != '0)
        timer_next = timer_reg - 24'h000001;
      else if (!walk_reg && !mem_wr_valid_o)
        busy_next = 1'b0;
      if (walk_reg && (!pvld_reg[widx_reg] || push_ready))
      begin
        widx_next = widx_reg + 8'h01;
        if (widx_reg == 8'hff)
          walk_next = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      phase_reg  <= PH_IDLE;
      op_reg     <= '0;
      shift_reg  <= '0;
      bits_reg   <= '0;
      addr_reg   <= '0;
      acnt_reg   <= '0;
      col_reg    <= '0;
      seen_reg   <= 1'b0;
      quad_reg   <= 1'b0;
      busy_reg   <= 1'b0;
      wlatch_reg <= 1'b0;
      timer_reg  <= '0;
      walk_reg   <= 1'b0;
      widx_reg   <= '0;
      row_reg    <= '0;
      clear_reg  <= '0;
      cvalid_reg <= 1'b0;
      pvld_reg   <= '0;
    end
    else if (ce_i)
    begin
      phase_reg  <= phase_next;
      op_reg     <= op_next;
      shift_reg  <= shift_next;
      bits_reg   <= bits_next;
      addr_reg   <= addr_next;
      acnt_reg   <= acnt_next;
      col_reg    <= col_next;
      seen_reg   <= seen_next;
      quad_reg   <= quad_next;
      busy_reg   <= busy_next;
      wlatch_reg <= wlatch_next;
      timer_reg  <= timer_next;
      walk_reg   <= walk_next;
      widx_reg   <= widx_next;
      row_reg    <= row_next;
      clear_reg  <= clear_next;
      cvalid_reg <= cvalid_next;
      if (vld_clr)
        pvld_reg <= '0;
      else if (buf_we)
        pvld_reg[col_reg] <= 1'b1;
    end
  end

  // Data storage needs no reset; only the valid marks decide what is written
  always_ff @(posedge mclk_i)
  begin
    if (ce_i && buf_we)
      pbuf[col_reg] <= shift_next;
  end

  flash_seq_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .mclk_i      (mclk_i),
    .nrst_i      (nrst_i),
    .ce_i        (ce_i),
    .in_data_i   ({row_reg, widx_reg, pbuf[widx_reg]}),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .out_data_o  (mem_wr_o),
    .out_valid_o (mem_wr_valid_o),
    .out_ready_i (mem_wr_ready_i)
  );

  assign clear_o            = clear_reg;
  assign clear_valid_o      = cvalid_reg;
  assign busy_status_flag_o = busy_reg;
  assign write_latch_flag_o = wlatch_reg;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  sequence seq_clear_start;
    clear_go && ce_i;
  endsequence

  sequence seq_clear_issue;
    cvalid_reg && busy_reg && !wlatch_reg;
  endsequence

  AST_START_NEEDS_LATCH: assert property (start |-> wlatch_reg)
    else $error("Cycle started with write latch clear");
  AST_NO_START_WHILE_BUSY: assert property (busy_reg |-> !start)
    else $error("Cycle started while busy");
  AST_LATCH_CLEARED: assert property ((start && ce_i) |=> !wlatch_reg && busy_reg)
    else $error("Latch not cleared at cycle start");
  AST_QUAD_ALLOWED: assert property ((prog_go && quad_reg) |-> quad_lane_allow_i)
    else $error("Four-lane program accepted while not allowed");
  AST_GUARD_BLOCKS: assert property (start |-> !prot)
    else $error("Guarded region accepted");
  AST_PROG_BOUNDARY: assert property (prog_go |-> bits_reg == 4'h0 && seen_reg)
    else $error("Program accepted off a byte boundary");
  AST_CLEAR_BOUNDARY: assert property (clear_go |-> phase_reg == PH_DATA && !seen_reg)
    else $error("Erase accepted off the address boundary");
  AST_CLEAR_ISSUE: assert property (seq_clear_start |=> seq_clear_issue)
    else $error("Erase request not issued with busy");
  AST_BUSY_HOLDS: assert property ($rose(busy_reg) |-> busy_reg[*2])
    else $error("Busy dropped immediately");
  AST_BUSY_ENDS: assert property ($fell(busy_reg) |->
                                  timer_reg == '0 && !walk_reg && !mem_wr_valid_o)
    else $error("Busy fell before cycle end");
  AST_BYTE_MARKED: assert property ((buf_we && ce_i && !vld_clr) |=> pvld_reg[$past(col_reg)])
    else $error("Received byte not marked for writing");

endmodule

// >>> hw/flash_seq_pkg.sv
package flash_seq_pkg;

  // Command opcodes
  localparam logic [7:0] WRITE_UNLOCK_OP           = 8'h06;
  localparam logic [7:0] BYTE_LOAD_OP              = 8'h02;
  localparam logic [7:0] WIDE_BYTE_LOAD_OP         = 8'h32;
  localparam logic [7:0] SMALL_REGION_CLEAR_OP     = 8'h20;
  localparam logic [7:0] LARGE_REGION_CLEAR_OP_32K = 8'h52;
  localparam logic [7:0] LARGE_REGION_CLEAR_OP_64K = 8'hd8;

  // Address layout
  localparam int          ADDR_W       = 24;
  localparam int          PAGE_W       = 8;
  localparam int          ROW_W        = ADDR_W - PAGE_W;
  localparam int          PAGE_BYTES   = 256;
  localparam logic [23:0] PAGE_MASK    = 24'h0000ff;
  localparam logic [23:0] SECTOR_MASK  = 24'h000fff;
  localparam logic [23:0] BLOCK32_MASK = 24'h007fff;
  localparam logic [23:0] BLOCK64_MASK = 24'h00ffff;
  localparam logic [1:0]  ADDR_BYTES_M1 = 2'h2;

  // Serial framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] SINGLE_STEP   = 4'h1;
  localparam logic [3:0] QUAD_STEP     = 4'h4;

  // Region guard decode: low field n guards 2^(n-1) regions (none if 0), next bit picks bottom,
  // top bit picks 4KB units instead of 64KB units
  localparam int GUARD_CNT_W    = 3;
  localparam int GUARD_BOTTOM   = 3;
  localparam int GUARD_FINE     = 4;
  localparam int GUARD_FINE_LOG = 12;
  localparam int GUARD_WIDE_LOG = 16;

  // Timing
  localparam int CLK_PERIOD_NS       = 25;
  localparam int LOAD_CYCLE_TIME_NS  = 500000;
  localparam int SMALL_CLEAR_TIME_NS = 2000000;
  localparam int LARGE_CLEAR_TIME_NS = 4000000;
  localparam int LOAD_CYCLES  = (LOAD_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SMALL_CYCLES = (SMALL_CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LARGE_CYCLES = (LARGE_CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W      = 24;

  // Write path buffering
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_W     = ADDR_W + 8;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_OPCODE = 2'b01,
    PH_ADDR   = 2'b11,
    PH_DATA   = 2'b10
  } phase_e;

  typedef enum logic [1:0] {
    CLR_SECTOR  = 2'b00,
    CLR_BLOCK32 = 2'b01,
    CLR_BLOCK64 = 2'b10
  } clear_size_e;

  typedef struct packed {
    logic       cs_n;
    logic       sclk;
    logic [3:0] lanes;
  } link_pins_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } mem_write_s;

  typedef struct packed {
    logic [ADDR_W-1:0] base;
    clear_size_e       size;
  } clear_req_s;

  localparam link_pins_s LINK_IDLE = '{cs_n: 1'b1, sclk: 1'b0, lanes: 4'h0};

endpackage

// >>> hw/flash_seq_fifo.sv
`timescale 1ns/1ps
module flash_seq_fifo
  import flash_seq_pkg::*;
#(
  parameter int W     = FIFO_W,
  parameter int DEPTH = FIFO_DEPTH
)(
  input  wire logic         mclk_i,
  input  wire logic         nrst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);

  // Shift structure keeps the head in a fixed flop, so the outputs are registered
  logic [W-1:0]     data_reg [DEPTH];
  logic [W-1:0]     data_next [DEPTH];
  logic [DEPTH-1:0] vld_reg;
  logic [DEPTH-1:0] vld_next;
  logic             placed;

  assign in_ready_o  = !vld_reg[DEPTH-1];
  assign out_data_o  = data_reg[0];
  assign out_valid_o = vld_reg[0];

  always_comb
  begin
    placed   = 1'b0;
    vld_next = vld_reg;
    for (int i = 0; i < DEPTH; i++)
      data_next[i] = data_reg[i];
    if (out_ready_i && vld_reg[0])
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        data_next[i] = data_reg[i+1];
        vld_next[i]  = vld_reg[i+1];
      end
      vld_next[DEPTH-1] = 1'b0;
    end
    for (int i = 0; i < DEPTH; i++)
    begin
      if (in_valid_i && in_ready_o && !placed && !vld_next[i])
      begin
        data_next[i] = in_data_i;
        vld_next[i]  = 1'b1;
        placed       = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      vld_reg <= '0;
      for (int i = 0; i < DEPTH; i++)
        data_reg[i] <= '0;
    end
    else if (ce_i)
    begin
      vld_reg <= vld_next;
      for (int i = 0; i < DEPTH; i++)
        data_reg[i] <= data_next[i];
    end
  end

endmodule

// >>> dv/flash_host_model.sv
`timescale 1ns/1ps
module flash_host_model
  import flash_seq_pkg::*;
(
  output link_pins_s link_o
);
  initial link_o = LINK_IDLE;

  task automatic start_f();
    link_o.cs_n = 1'b0;
    #200;
  endtask

  // Mode 0: lanes move while sclk is low, the device samples on the rise
  task automatic put(input logic [7:0] b, input bit quad, input int nclk);
    logic [7:0] s;
    s = b;
    for (int i = 0; i < nclk; i++)
    begin
      if (quad)
        link_o.lanes = s[7:4];
      else
        link_o.lanes = {~link_o.lanes[3:1], s[7]};
      s = quad ? {s[3:0], 4'h0} : {s[6:0], 1'b0};
      #100 link_o.sclk = 1'b1;
      #100 link_o.sclk = 1'b0;
    end
  endtask

  // Released lanes show the inverse so stale data is never mistaken for valid
  task automatic stop_f();
    #100 link_o.cs_n = 1'b1;
    link_o.lanes = ~link_o.lanes;
    #1000;
  endtask
endmodule

// >>> dv/tb_spi_flash_program_erase.sv
`timescale 1ns/1ps
module tb_spi_flash_program_erase
  import flash_seq_pkg::*;
;
  localparam int LC = 40;
  localparam int SC = 900;
  localparam int BC = 1000;
  logic        mclk = 1'b0;
  logic        nrst_n = 1'b0;
  logic        ce = 1'b1;
  logic        qe = 1'b0;
  logic        ready = 1'b0;
  logic [4:0]  guard = 5'h00;
  link_pins_s  link;
  mem_write_s  wr;
  clear_req_s  clr;
  clear_req_s  last_clr;
  logic        wr_v;
  logic        clr_v;
  logic        busy;
  logic        latch;
  int          err_count = 0;
  int          tests_run = 0;
  int          busy_cnt = 0;
  int          clr_cnt = 0;
  int          cyc = 0;
  bit          seeded = 0;
  logic [23:0] ea;
  mem_write_s  got[$];
  logic [7:0]  dat[$];
  logic [7:0]  expc[int];
  logic [7:0]  ops[3] = '{SMALL_REGION_CLEAR_OP, LARGE_REGION_CLEAR_OP_32K,
                          LARGE_REGION_CLEAR_OP_64K};

  always #12.5 mclk = ~mclk;

  flash_host_model host (.link_o(link));

  flash_seq_top #(.LOAD_CYCLE_CNT(LC), .SMALL_CLEAR_CNT(SC), .LARGE_CLEAR_CNT(BC)) dut (
    .mclk_i             (mclk),
    .nrst_i             (nrst_n),
    .ce_i               (ce),
    .link_i             (link),
    .quad_lane_allow_i  (qe),
    .region_guard_bits_i(guard),
    .mem_wr_o           (wr),
    .mem_wr_valid_o     (wr_v),
    .mem_wr_ready_i     (ready),
    .clear_o            (clr),
    .clear_valid_o      (clr_v),
    .busy_status_flag_o (busy),
    .write_latch_flag_o (latch)
  );

  // Random stalls keep the write FIFO filling and draining
  always @(negedge mclk)
    if (seeded)
      ready <= ($urandom % 4) != 0;

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (wr_v === 1'b1 && ready)
      got.push_back(wr);
    if (busy === 1'b1)
      busy_cnt <= busy_cnt + 1;
    if (clr_v === 1'b1)
    begin
      clr_cnt <= clr_cnt + 1;
      last_clr <= clr;
    end
    if (cyc == 60000)
    begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic frame(input logic [7:0] op, input logic [23:0] a, input bit quad,
                       input int extra);
    host.start_f();
    host.put(op, 1'b0, 8);
    for (int i = 2; i >= 0; i--)
      host.put(a[8*i+:8], quad, quad ? 2 : 8);
    foreach (dat[i])
      host.put(dat[i], quad, quad ? 2 : 8);
    if (extra > 0)
      host.put(8'h5a, quad, extra);
    host.stop_f();
  endtask

  task automatic unlock();
    host.start_f();
    host.put(WRITE_UNLOCK_OP, 1'b0, 8);
    host.stop_f();
    chk(latch, 1'b1);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 3000 && busy !== 1'b0; i++)
      @(negedge mclk);
    repeat (8) @(negedge mclk);
  endtask

  task automatic prog(input logic [23:0] a, input int n, input bit quad, input int extra,
                      input bit lk, input bit go);
    int j;
    dat = {};
    expc.delete();
    got = {};
    busy_cnt = 0;
    j = 0;
    repeat (n) dat.push_back(8'($urandom));
    for (int k = 0; k < n; k++)
      expc[(a[7:0] + k) % 256] = dat[k];
    frame(quad ? WIDE_BYTE_LOAD_OP : BYTE_LOAD_OP, a, quad, extra);
    chk(busy, go);
    chk(latch, lk & !go);
    wait_idle();
    chk(busy, 1'b0);
    chk(go ? busy_cnt >= LC : busy_cnt == 0, 1'b1);
    chk(got.size(), go ? expc.num() : 0);
    for (int c = 0; c < 256; c++)
      if (go && expc.exists(c) && j < got.size())
      begin
        chk(got[j], {a[23:8], 8'(c), expc[c]});
        j++;
      end
    $display("program test finished at %0t", $time);
  endtask

  task automatic erase(input logic [7:0] op, input logic [23:0] a, input int extra,
                       input bit go);
    logic [23:0] m;
    clear_size_e s;
    int          c;
    m = BLOCK64_MASK;
    s = CLR_BLOCK64;
    c = BC;
    if (op == SMALL_REGION_CLEAR_OP)
    begin
      m = SECTOR_MASK;
      s = CLR_SECTOR;
      c = SC;
    end
    if (op == LARGE_REGION_CLEAR_OP_32K)
    begin
      m = BLOCK32_MASK;
      s = CLR_BLOCK32;
    end
    dat = {};
    busy_cnt = 0;
    clr_cnt = 0;
    frame(op, a, 1'b0, extra);
    chk(clr_cnt, go);
    if (go)
      chk(last_clr, {a & ~m, s});
    wait_idle();
    chk(go ? busy_cnt >= c && busy_cnt <= c + 4 : busy_cnt == 0, 1'b1);
    $display("erase test finished at %0t", $time);
  endtask

  initial
  begin
    void'($urandom(5));
    seeded = 1;
    repeat (5) @(negedge mclk);
    nrst_n = 1'b1;
    repeat (2) @(negedge mclk);
    prog(24'h001200, 4, 0, 0, 0, 0);
    unlock();
    prog(24'h0034f0, 20, 0, 0, 1, 1);
    unlock();
    prog(24'h004505, 260, 0, 0, 1, 1);
    unlock();
    prog(24'h005600, 3, 0, 4, 1, 0);
    prog(24'h005700, 3, 1, 0, 1, 0);
    qe = 1'b1;
    prog(24'h0058fe, 5, 1, 0, 1, 1);
    guard = 5'h01;
    unlock();
    prog(24'hff1200, 2, 0, 0, 1, 0);
    erase(SMALL_REGION_CLEAR_OP, 24'hff8123, 0, 0);
    guard = 5'h00;
    erase(SMALL_REGION_CLEAR_OP, 24'h0a0123, 1, 0);
    foreach (ops[i])
    begin
      unlock();
      erase(ops[i], 24'($urandom) & 24'h7fffff, 0, 1);
    end
    // Reset in mid-erase, then the host repeats the same erase
    ea = 24'($urandom) & 24'h7fffff;
    unlock();
    dat = {};
    frame(LARGE_REGION_CLEAR_OP_64K, ea, 1'b0, 0);
    // Clock enable low freezes the timer, so busy outlives the whole erase time
    ce = 1'b0;
    repeat (BC + 100) @(negedge mclk);
    chk(busy, 1'b1);
    chk(latch, 1'b0);
    ce = 1'b1;
    nrst_n = 1'b0;
    repeat (2) @(negedge mclk);
    chk({busy, latch}, 2'b00);
    nrst_n = 1'b1;
    repeat (2) @(negedge mclk);
    unlock();
    erase(LARGE_REGION_CLEAR_OP_64K, ea, 0, 1);
    // A program frame sent while an erase is still running must not write
    unlock();
    busy_cnt = 0;
    dat = {};
    frame(SMALL_REGION_CLEAR_OP, 24'h012345, 1'b0, 0);
    got = {};
    dat = {8'h11};
    frame(BYTE_LOAD_OP, 24'h012300, 1'b0, 0);
    chk(busy, 1'b1);
    wait_idle();
    chk(got.size(), 0);
    chk(busy_cnt >= SC && busy_cnt <= SC + 4, 1'b1);
    $display("busy test finished at %0t", $time);
    report_and_stop();
  end
endmodule
